/* logic/ccn_params.svh */
`ifndef CCN_PARAMS_SVH
`define CCN_PARAMS_SVH

// Register byte offsets on the AXI4-Lite port
`define CCN_REG_CONTROL 8'h00
`define CCN_REG_ACCEPT_CODE 8'h04
`define CCN_REG_ACCEPT_MASK 8'h08
`define CCN_REG_TIMING 8'h0C
`define CCN_REG_STATUS 8'h10
`define CCN_REG_COUNTS 8'h14

// Control register fields
`define CCN_CTRL_NODE_LSB 0
`define CCN_CTRL_NODE_MSB 6
`define CCN_CTRL_WACK_BIT 8

// Timing register fields
`define CCN_TIM_PRESCALE_LSB 0
`define CCN_TIM_PRESCALE_MSB 7
`define CCN_TIM_SEG1_LSB 8
`define CCN_TIM_SEG1_MSB 11
`define CCN_TIM_SEG2_LSB 12
`define CCN_TIM_SEG2_MSB 14

// Status register bits, write one to clear
`define CCN_ST_RX_BIT 0
`define CCN_ST_TX_BIT 1
`define CCN_ST_WBERR_BIT 2
`define CCN_ST_ALERT_BIT 3

// Reset values
`define CCN_RST_NODE 7'h00
`define CCN_RST_WACK 1'b1
`define CCN_RST_PRESCALE 8'h04
`define CCN_RST_SEG1 4'h7
`define CCN_RST_SEG2 3'h3
`define CCN_RST_ACCEPT_CODE 11'h000
`define CCN_RST_ACCEPT_MASK 11'h7FF

// Command codes carried in the low identifier nibble
`define CCN_CMD_DATA 4'h1
`define CCN_CMD_WRITE 4'h2
`define CCN_CMD_WRITE_RESP 4'h3
`define CCN_CMD_READ 4'h4
`define CCN_CMD_READ_RESP 4'h5
`define CCN_CMD_ALERT 4'h7

// Write response status values
`define CCN_WSTAT_OK 8'h00
`define CCN_WSTAT_BUS_ERR 8'h01
`define CCN_WSTAT_SHORT 8'h02

`endif

/* logic/ccn_pkg.sv */
package ccn_pkg;

    // One CAN frame as passed to and from the protocol controller
    typedef struct packed {
        logic extended;
        logic [28:0] identifier;
        logic [3:0] length;
        logic [63:0] payload;
    } ccn_frame_t;

    // Register access towards the local bus
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [15:0] adr;
        logic [15:0] dat;
    } ccn_wb_req_t;

    typedef enum logic [2:0] {
        CCN_IDLE = 3'b001,
        CCN_BUS = 3'b010,
        CCN_SEND = 3'b100
    } ccn_state_t;

endpackage

/* logic/ccn_node.sv */
`timescale 1ns/1ps
`include "ccn_params.svh"
module ccn_node (
    input wire logic clk,
    input wire logic reset,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Frames from the protocol controller
    input wire ccn_pkg::ccn_frame_t rx_frame,
    input wire logic rx_valid,
    output logic rx_ready,
    // Frames to the protocol controller
    output ccn_pkg::ccn_frame_t tx_frame,
    output logic tx_valid,
    input wire logic tx_ready,
    // Register bus master
    output ccn_pkg::ccn_wb_req_t wb_req,
    input wire logic [15:0] wb_dat_i,
    input wire logic wb_ack,
    input wire logic wb_err,
    // Bit timing strobes for the controller, then the interrupt output
    output logic quantum_tick,
    output logic bit_start,
    output logic bit_sample,
    output logic irq_n
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Builds a standard response frame for this node
    function automatic ccn_pkg::ccn_frame_t make_resp(
        input logic [6:0] node,
        input logic [3:0] cmd,
        input logic [3:0] len,
        input logic [63:0] data
    );
        ccn_pkg::ccn_frame_t f;
        f.extended = 1'b0;
        f.identifier = {18'h00000, node, cmd};
        f.length = len;
        f.payload = data;
        return f;
    endfunction

    // Byte n of a payload, byte 0 in the top lane
    function automatic logic [7:0] pay_byte(
        input logic [63:0] p,
        input int n
    );
        return p[63 - 8 * n -: 8];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Configuration and status registers

    logic [6:0] node_addr;
    logic write_ack_en;
    logic [10:0] accept_code;
    logic [10:0] accept_mask;
    logic [7:0] prescale;
    logic [3:0] seg1;
    logic [2:0] seg2;
    logic [3:0] status;
    logic [7:0] data_count;
    logic [7:0] alert_count;
    logic [7:0] drop_count;

    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Address and data may arrive in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire [7:0] wr_addr = aw_fire ? s_axi_awaddr : aw_addr;
    wire [31:0] wr_data = w_fire ? s_axi_wdata : w_data;
    wire [3:0] wr_strb = w_fire ? s_axi_wstrb : w_strb;
    wire wr_go = (aw_held || aw_fire) && (w_held || w_fire);

    wire wr_ctrl = wr_go && wr_addr == `CCN_REG_CONTROL;
    wire wr_code = wr_go && wr_addr == `CCN_REG_ACCEPT_CODE;
    wire wr_mask = wr_go && wr_addr == `CCN_REG_ACCEPT_MASK;
    wire wr_tim = wr_go && wr_addr == `CCN_REG_TIMING;
    wire wr_stat = wr_go && wr_addr == `CCN_REG_STATUS;
    wire wr_known = wr_ctrl || wr_code || wr_mask || wr_tim || wr_stat
        || (wr_go && wr_addr == `CCN_REG_COUNTS);

    // Read decode; the counts word is read only
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire [7:0] ra = s_axi_araddr;
    wire rd_known = ra == `CCN_REG_CONTROL || ra == `CCN_REG_ACCEPT_CODE
        || ra == `CCN_REG_ACCEPT_MASK || ra == `CCN_REG_TIMING
        || ra == `CCN_REG_STATUS || ra == `CCN_REG_COUNTS;
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (ra)
            `CCN_REG_CONTROL: rd_mux = {23'h000000, write_ack_en, 1'b0,
                node_addr};
            `CCN_REG_ACCEPT_CODE: rd_mux = {21'h000000, accept_code};
            `CCN_REG_ACCEPT_MASK: rd_mux = {21'h000000, accept_mask};
            `CCN_REG_TIMING: rd_mux = {17'h00000, seg2, seg1, prescale};
            `CCN_REG_STATUS: rd_mux = {28'h0000000, status};
            `CCN_REG_COUNTS: rd_mux = {8'h00, drop_count, alert_count,
                data_count};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Write channel holding and response
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (aw_fire) aw_addr <= s_axi_awaddr;
            if (w_fire) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            aw_held <= wr_go ? 1'b0 : (aw_held || aw_fire);
            w_held <= wr_go ? 1'b0 : (w_held || w_fire);
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel; unmapped reads answer SLVERR with zero data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_known ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Configuration fields, byte lanes honoured
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            node_addr <= `CCN_RST_NODE;
            write_ack_en <= `CCN_RST_WACK;
            accept_code <= `CCN_RST_ACCEPT_CODE;
            accept_mask <= `CCN_RST_ACCEPT_MASK;
            prescale <= `CCN_RST_PRESCALE;
            seg1 <= `CCN_RST_SEG1;
            seg2 <= `CCN_RST_SEG2;
        end else begin
            if (wr_ctrl && wr_strb[0]) node_addr <= wr_data[6:0];
            if (wr_ctrl && wr_strb[1]) write_ack_en <= wr_data[8];
            if (wr_code && wr_strb[0]) accept_code[7:0] <= wr_data[7:0];
            if (wr_code && wr_strb[1]) accept_code[10:8] <= wr_data[10:8];
            if (wr_mask && wr_strb[0]) accept_mask[7:0] <= wr_data[7:0];
            if (wr_mask && wr_strb[1]) accept_mask[10:8] <= wr_data[10:8];
            if (wr_tim && wr_strb[0]) prescale <= wr_data[7:0];
            if (wr_tim && wr_strb[1]) begin
                seg1 <= wr_data[11:8];
                seg2 <= wr_data[14:12];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit timing: one sync quantum, seg1 before sampling, seg2 after

    logic [7:0] tq_count;
    logic [4:0] q_count;
    // A zero prescale would stall the divider, so treat it as one
    wire [7:0] tq_last = (prescale == 8'h00) ? 8'h00 : prescale - 8'h01;
    wire [4:0] bit_quanta = 5'(1 + seg1 + seg2);
    wire tq_end = tq_count == tq_last;
    assign quantum_tick = tq_end;
    assign bit_start = tq_end && q_count == 5'h00;
    assign bit_sample = tq_end && q_count == 5'(seg1);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tq_count <= 8'h00;
            q_count <= 5'h00;
        end else begin
            tq_count <= tq_end ? 8'h00 : tq_count + 8'h01;
            if (tq_end) begin
                q_count <= (q_count >= bit_quanta - 5'h01) ? 5'h00
                    : q_count + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame decode

    ccn_pkg::ccn_state_t state;
    logic [15:0] req_addr;
    logic req_write;
    logic [63:0] resp_data;
    logic [3:0] resp_len;
    logic [3:0] resp_cmd;

    wire [10:0] std_id = rx_frame.identifier[10:0];
    wire [6:0] rx_node = std_id[10:4];
    wire [3:0] rx_cmd = std_id[3:0];
    // Extended frames are accepted by the controller but carry no command
    wire std_frame = !rx_frame.extended;
    wire id_pass = ((std_id ^ accept_code) & ~accept_mask) == 11'h000;
    wire for_me = std_frame && id_pass && rx_node == node_addr;
    wire rx_take = rx_valid && rx_ready;
    wire [15:0] rx_addr = {pay_byte(rx_frame.payload, 0),
        pay_byte(rx_frame.payload, 1)};
    wire [15:0] rx_wdata = {pay_byte(rx_frame.payload, 2),
        pay_byte(rx_frame.payload, 3)};
    wire is_write = for_me && rx_cmd == `CCN_CMD_WRITE;
    wire is_read = for_me && rx_cmd == `CCN_CMD_READ;
    wire write_ok = is_write && rx_frame.length >= 4'h4;
    wire read_ok = is_read && rx_frame.length >= 4'h2;
    wire is_data = for_me && rx_cmd == `CCN_CMD_DATA;
    wire is_alert = for_me && rx_cmd == `CCN_CMD_ALERT;
    wire wb_done = wb_ack || wb_err;

    assign rx_ready = state == ccn_pkg::CCN_IDLE;
    assign tx_valid = state == ccn_pkg::CCN_SEND;

    ////////////////////////////////////////////////////////////////////////
    // Transaction sequencer

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ccn_pkg::CCN_IDLE;
            req_addr <= 16'h0000;
            req_write <= 1'b0;
            wb_req <= '0;
            tx_frame <= '0;
        end else begin
            unique case (state)
                ccn_pkg::CCN_IDLE: begin
                    if (rx_take && (write_ok || read_ok)) begin
                        state <= ccn_pkg::CCN_BUS;
                        req_addr <= rx_addr;
                        req_write <= write_ok;
                        wb_req.cyc <= 1'b1;
                        wb_req.stb <= 1'b1;
                        wb_req.we <= write_ok;
                        wb_req.adr <= rx_addr;
                        wb_req.dat <= rx_wdata;
                    end else if (rx_take && is_write && write_ack_en) begin
                        // Too short to carry data: refuse with a status
                        state <= ccn_pkg::CCN_SEND;
                        tx_frame <= make_resp(node_addr,
                            `CCN_CMD_WRITE_RESP, 4'h3,
                            {rx_addr, `CCN_WSTAT_SHORT, 40'h0});
                    end else if (rx_take && is_read) begin
                        state <= ccn_pkg::CCN_SEND;
                        tx_frame <= make_resp(node_addr,
                            `CCN_CMD_READ_RESP, 4'h2,
                            {rx_addr, 48'h0});
                    end
                end
                ccn_pkg::CCN_BUS: begin
                    if (wb_done) begin
                        wb_req.cyc <= 1'b0;
                        wb_req.stb <= 1'b0;
                        if (req_write && !write_ack_en) begin
                            state <= ccn_pkg::CCN_IDLE;
                        end else begin
                            state <= ccn_pkg::CCN_SEND;
                        end
                        if (req_write) begin
                            tx_frame <= make_resp(node_addr,
                                `CCN_CMD_WRITE_RESP, 4'h3, {req_addr,
                                wb_err ? `CCN_WSTAT_BUS_ERR
                                : `CCN_WSTAT_OK, 40'h0});
                        end else if (wb_err) begin
                            tx_frame <= make_resp(node_addr,
                                `CCN_CMD_READ_RESP, 4'h2,
                                {req_addr, 48'h0});
                        end else begin
                            tx_frame <= make_resp(node_addr,
                                `CCN_CMD_READ_RESP, 4'h4,
                                {req_addr, wb_dat_i, 32'h0});
                        end
                    end
                end
                ccn_pkg::CCN_SEND: begin
                    if (tx_ready) state <= ccn_pkg::CCN_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky events; a new event wins over a clear in the same cycle

    wire tx_done = tx_valid && tx_ready;
    wire bus_err = state == ccn_pkg::CCN_BUS && wb_err;
    wire [3:0] events = {rx_take && is_alert, bus_err, tx_done,
        rx_take && id_pass};
    wire [3:0] clear = (wr_stat && wr_strb[0]) ? wr_data[3:0] : 4'h0;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status <= 4'h0;
            data_count <= 8'h00;
            alert_count <= 8'h00;
            drop_count <= 8'h00;
        end else begin
            status <= (status & ~clear) | events;
            if (rx_take && is_data) data_count <= data_count + 8'h01;
            if (rx_take && is_alert) alert_count <= alert_count + 8'h01;
            if (rx_take && !for_me) drop_count <= drop_count + 8'h01;
        end
    end

    // Low while a transmit or receive event is pending
    assign irq_n = !(status[`CCN_ST_RX_BIT] || status[`CCN_ST_TX_BIT]);

endmodule

/* sim/ccn_node_properties.sv */
`timescale 1ns/1ps
// Port-level protocol checks for the command node
module ccn_node_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire ccn_pkg::ccn_frame_t tx_frame,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire ccn_pkg::ccn_wb_req_t wb_req,
    input wire logic wb_ack,
    input wire logic wb_err,
    input wire logic quantum_tick,
    input wire logic bit_start,
    input wire logic bit_sample
);
    logic [3:0] cmd;
    logic [7:0] stat;
    logic done;
    // Response fields; timing checks assume the reset bit timing
    assign cmd = tx_frame.identifier[3:0];
    assign stat = tx_frame.payload[47:40];
    assign done = wb_req.cyc && (wb_ack || wb_err);

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////
    // A write acknowledge is optional, so only reads must always answer
    a_bus_release: assert property (done |=> !wb_req.cyc)
        else $error("bus cycle not closed");
    a_read_reply: assert property (done && !wb_req.we |=> tx_valid)
        else $error("read cycle not answered");
    a_write_ok: assert property (done && wb_req.we && !wb_err |=>
        cmd == 4'h3 && tx_frame.length == 4'h3 && stat == 8'h00)
        else $error("good write not answered with zero status");
    a_write_err: assert property (done && wb_req.we && wb_err |=>
        cmd == 4'h3 && stat != 8'h00)
        else $error("failed write answered with zero status");
    a_read_ok: assert property (done && !wb_req.we && !wb_err |=>
        cmd == 4'h5 && tx_frame.length == 4'h4)
        else $error("good read answer malformed");
    a_read_short: assert property (done && !wb_req.we && wb_err |=>
        cmd == 4'h5 && tx_frame.length == 4'h2)
        else $error("failed read answer not short");
    a_tx_hold: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_frame))
        else $error("outgoing frame changed before taken");
    a_tx_ident: assert property (tx_valid |-> !tx_frame.extended &&
        tx_frame.identifier[28:11] == 18'h00000)
        else $error("response identifier not standard");
    a_tick_period: assert property (quantum_tick |=>
        !quantum_tick [*3] ##1 quantum_tick)
        else $error("quantum tick period wrong");
    a_sample_point: assert property (bit_start |-> ##28 bit_sample)
        else $error("sample point misplaced");
    a_bit_period: assert property (bit_start |-> ##44 bit_start)
        else $error("bit period wrong");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid)
        else $error("register read not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid)
        else $error("write response dropped early");

    c_write: cover property (done && wb_req.we);
    c_read_err: cover property (done && !wb_req.we && wb_err);
    c_sample: cover property (bit_sample);
endmodule

/* sim/ccn_bus_peer.sv */
`timescale 1ns/1ps
// Local register bus slave; page FF is unmapped and answers with error
module ccn_bus_peer (
    input wire logic clk,
    input wire logic reset,
    input wire ccn_pkg::ccn_wb_req_t wb_req,
    output logic [15:0] wb_dat_i,
    output logic wb_ack,
    output logic wb_err
);
    logic [15:0] mem [256];
    logic [15:0] rdat;
    logic [1:0] cnt;
    logic slow;
    logic hit;
    logic bad;
    // Replies; data is inverted when no reply is given so nothing stale looks valid
    assign bad = wb_req.adr[15:8] == 8'hFF;
    assign wb_ack = hit && !bad;
    assign wb_err = hit && bad;
    assign wb_dat_i = hit ? rdat : ~rdat;
    // One reply a request, prompt and slow (3 waits) in turn
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hit <= 1'b0;
            cnt <= 2'h0;
            slow <= 1'b0;
        end else if (wb_req.cyc && wb_req.stb && !hit) begin
            if (!slow || cnt == 2'h3) begin
                hit <= 1'b1;
                slow <= ~slow;
                cnt <= 2'h0;
                rdat <= mem[wb_req.adr[7:0]];
                if (wb_req.we && !bad) begin
                    mem[wb_req.adr[7:0]] <= wb_req.dat;
                end
            end else begin
                cnt <= cnt + 2'h1;
            end
        end else begin
            hit <= 1'b0;
        end
    end
endmodule

/* sim/ccn_node_tb.sv */
`timescale 1ns/1ps
module ccn_node_tb;
    logic clk, reset;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    ccn_pkg::ccn_frame_t rx_frame, tx_frame, f;
    ccn_pkg::ccn_wb_req_t wb_req;
    logic rx_valid, rx_ready, tx_valid, tx_ready, wb_ack, wb_err;
    logic [15:0] wb_dat_i;
    logic quantum_tick, bit_start, bit_sample, irq_n;
    int errors, tests_run, cycles;

    ccn_node dut (.clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .rx_frame(rx_frame), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_frame(tx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .wb_req(wb_req), .wb_dat_i(wb_dat_i), .wb_ack(wb_ack),
        .wb_err(wb_err), .quantum_tick(quantum_tick),
        .bit_start(bit_start), .bit_sample(bit_sample), .irq_n(irq_n));
    ccn_bus_peer peer (.clk(clk), .reset(reset), .wb_req(wb_req),
        .wb_dat_i(wb_dat_i), .wb_ack(wb_ack), .wb_err(wb_err));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the whole run needs a few hundred cycles
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time,
                seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Counts: %0d checks, %0d mismatches", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Register write; address and data released each on its own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // Waits for bvalid; if it never comes, only the bench timeout ends this wait
        do begin
            @(posedge clk);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
        // Idle edge so the next call never re-drives bready in this step
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, er);
        @(posedge clk);
    endtask

    // Frame to the node; held until the node takes it
    task automatic snd(input logic [6:0] nd, input logic [3:0] c,
                       input logic ext, input logic [3:0] len,
                       input logic [31:0] p);
        rx_frame <= {ext, 18'h00000, nd, c, len, p, 32'h00000000};
        rx_valid <= 1'b1;
        do @(posedge clk); while (!rx_ready);
        rx_valid <= 1'b0;
    endtask

    // Take one answer, stalling two cycles first
    task automatic get(input logic [3:0] c, input logic [3:0] len);
        do @(posedge clk); while (!tx_valid);
        f = tx_frame;
        repeat (2) @(posedge clk);
        tx_ready <= 1'b1;
        @(posedge clk);
        tx_ready <= 1'b0;
        chk({f.extended, f.identifier, f.length},
            {1'b0, 18'h00000, 7'h15, c, len});
    endtask

    // Frame must be consumed with no answer at all
    task automatic quiet();
        logic seen;
        seen = 1'b0;
        repeat (30) begin
            @(posedge clk);
            seen |= tx_valid;
        end
        chk(seen, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, rx_valid, tx_ready} = '0;
        s_axi_wstrb = 4'hF;
        rx_frame = '0;
        errors = 0;
        tests_run = 0;
        cycles = 0;
        reset = 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // Reset values, unmapped place, node address
        rd(8'h0C, 2'b00);
        chk(d, 32'h00003704);
        rd(8'h08, 2'b00);
        chk(d, 32'h000007FF);
        rd(8'h20, 2'b10);
        chk(d, 32'h00000000);
        wr(8'h20, 32'h0000FFFF, 2'b10);
        wr(8'h00, 32'h00000115, 2'b00);
        rd(8'h00, 2'b00);
        chk(d, 32'h00000115);
        $display("Test registers done");
        // Write then read back, status and interrupt
        snd(7'h15, 4'h2, 1'b0, 4'h4, 32'h1234ABCD);
        get(4'h3, 4'h3);
        chk(f.payload[63:40], 24'h123400);
        chk(peer.mem[8'h34], 16'hABCD);
        chk(irq_n, 1'b0);
        wr(8'h10, 32'h00000003, 2'b00);
        chk(irq_n, 1'b1);
        snd(7'h15, 4'h4, 1'b0, 4'h2, 32'h12340000);
        get(4'h5, 4'h4);
        chk(f.payload[63:32], 32'h1234ABCD);
        $display("Test write and read done");
        // Bus errors on both kinds
        snd(7'h15, 4'h4, 1'b0, 4'h2, 32'hFF000000);
        get(4'h5, 4'h2);
        chk(f.payload[63:48], 16'hFF00);
        snd(7'h15, 4'h2, 1'b0, 4'h4, 32'hFF010005);
        get(4'h3, 4'h3);
        chk(f.payload[47:40] != 8'h00, 1'b1);
        // Short write answers an error; then acknowledge turned off
        snd(7'h15, 4'h2, 1'b0, 4'h2, 32'h00360000);
        get(4'h3, 4'h3);
        chk(f.payload[63:48], 16'h0036);
        chk(f.payload[47:40] != 8'h00, 1'b1);
        wr(8'h00, 32'h00000015, 2'b00);
        snd(7'h15, 4'h2, 1'b0, 4'h4, 32'h00355A5A);
        quiet();
        chk(peer.mem[8'h35], 16'h5A5A);
        wr(8'h00, 32'h00000115, 2'b00);
        $display("Test errors done");
        // Frames that must draw no answer, then one the reopened filter passes
        snd(7'h16, 4'h4, 1'b0, 4'h2, 32'h12340000);
        quiet();
        snd(7'h15, 4'h4, 1'b1, 4'h2, 32'h12340000);
        quiet();
        snd(7'h15, 4'h1, 1'b0, 4'h2, 32'h55AA0000);
        quiet();
        snd(7'h15, 4'h7, 1'b0, 4'h1, 32'h01000000);
        quiet();
        rd(8'h14, 2'b00);
        chk(d[23:0], 24'h020101);
        rd(8'h10, 2'b00);
        chk(d, 32'h0000000F);
        wr(8'h04, 32'h00000152, 2'b00);
        wr(8'h08, 32'h00000000, 2'b00);
        snd(7'h15, 4'h4, 1'b0, 4'h2, 32'h12340000);
        quiet();
        wr(8'h08, 32'h000007FF, 2'b00);
        snd(7'h15, 4'h4, 1'b0, 4'h2, 32'h12340000);
        get(4'h5, 4'h4);
        $display("Test filtering done");
        print_verdict();
    end
endmodule

bind ccn_node ccn_node_properties u_props (.clk(clk), .reset(reset),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .tx_frame(tx_frame),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .wb_req(wb_req),
    .wb_ack(wb_ack), .wb_err(wb_err), .quantum_tick(quantum_tick),
    .bit_start(bit_start), .bit_sample(bit_sample));
